/* core_status_control.sv */
/*
 * Supervisor status word, exception table base, cache, region, on-chip
 * RAM and peripheral window control registers, plus the sixteen general
 * registers with size-aware writes.
 * Assumes the execute stage presents one register operation per cycle
 * and decides exceptions from the status outputs given here.
 */
`timescale 1ns/1ns
`include "core_status_control_defines.svh"

module core_status_control
	import core_status_control_pkg::*;
#(
	parameter logic [31:0] CACHE_IMPL_MASK  = 32'hFFFF_FFFF,
	parameter logic [31:0] REGION_IMPL_MASK = 32'hFFFF_FFFF,
	parameter logic [31:0] RAM_IMPL_MASK    = 32'hFFFF_FFFF,
	parameter logic [31:0] PERIPH_IMPL_MASK = 32'hFFFF_FFFF
) (
	input  wire logic           mclk_i,
	input  wire logic           reset_n_i,
	// Status word access
	input  wire status_target_t status_sel_i,
	input  wire logic           status_wr_i,
	input  wire logic [15:0]    status_wdata_i,
	output logic      [15:0]    status_rdata_o,
	output logic                status_priv_fault_o,
	// Arithmetic flag update
	input  wire logic           flags_wr_i,
	input  wire logic [4:0]     flags_i,
	// Exception entry
	input  wire logic           irq_taken_i,
	input  wire logic [2:0]     irq_level_i,
	input  wire logic           irq_edge7_i,
	output logic                irq_accept_o,
	input  wire logic           insn_done_i,
	output logic                trace_req_o,
	output logic                supervisor_o,
	input  wire logic [9:0]     vector_disp_i,
	output logic      [31:0]    vector_addr_o,
	// Control register move
	input  wire logic           ctl_wr_i,
	input  wire logic [11:0]    ctl_sel_i,
	input  wire logic [31:0]    ctl_wdata_i,
	output logic      [31:0]    ctl_rdata_o,
	output logic                ctl_fault_o,
	output logic      [31:0]    cache_control_o,
	output logic      [31:0]    region_attr_0_o,
	output logic      [31:0]    region_attr_1_o,
	output logic      [31:0]    ram_base_o,
	output logic      [31:0]    periph_base_o,
	// General registers
	input  wire logic           gpr_wr_i,
	input  wire logic [3:0]     gpr_wsel_i,
	input  wire op_size_t       gpr_size_i,
	input  wire logic [31:0]    gpr_wdata_i,
	input  wire logic [3:0]     gpr_rsel_i,
	output logic      [31:0]    gpr_rdata_o,
	output logic                gpr_size_fault_o
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [15:0] psw_reg;
	logic [15:0] psw_next;
	logic [31:0] exc_base_reg;
	logic [31:0] exc_base_next;
	logic [31:0] cache_reg;
	logic [31:0] cache_next;
	logic [31:0] region0_reg;
	logic [31:0] region0_next;
	logic [31:0] region1_reg;
	logic [31:0] region1_next;
	logic [31:0] ram_base_reg;
	logic [31:0] ram_base_next;
	logic [31:0] periph_reg;
	logic [31:0] periph_next;
	logic [31:0] gpr_reg [16];
	logic [31:0] gpr_next [16];
	logic [31:0] merged;
	logic        is_super;
	logic        addr_byte;

	assign is_super = psw_reg[`PSW_SUPER_BIT];

	// ------------------------------------------------------------------
	// Status word
	// ------------------------------------------------------------------
	always_comb begin
		psw_next            = psw_reg;
		status_priv_fault_o = 1'b0;
		// All status accesses carry 16 bits
		if (status_wr_i) begin
			unique case (status_sel_i)
				STATUS_WHOLE: begin
					if (is_super) begin
						psw_next = status_wdata_i & `PSW_WRITE_MASK;
					end else begin
						status_priv_fault_o = 1'b1;
					end
				end
				STATUS_FLAGS: begin
					// Upper byte ignored in either mode
					psw_next = {psw_reg[15:8],
						status_wdata_i[7:0] & `FLAG_WRITE_MASK};
				end
				default: psw_next = psw_reg;
			endcase
		end else if (status_sel_i == STATUS_WHOLE && !is_super) begin
			status_priv_fault_o = 1'b1;
		end
		// Arithmetic result flags land after any explicit write
		if (flags_wr_i) begin
			psw_next[`PSW_FLAG_HI:0] = flags_i;
		end
		// Interrupt entry: supervisor set, master and trace cleared, mask set to irq_level_i
		if (irq_taken_i) begin
			psw_next[`PSW_MASTER_BIT] = 1'b0;
			psw_next[`PSW_SUPER_BIT]  = 1'b1;
			psw_next[`PSW_TRACE_BIT]  = 1'b0;
			psw_next[`PSW_MASK_HI:`PSW_MASK_LO] = irq_level_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			// Flags undefined by design; cleared here for determinism
			psw_reg <= {`PSW_RESET_HIGH, `PSW_RESET_FLAGS};
		end else begin
			psw_reg <= psw_next;
		end
	end

	always_comb begin
		unique case (status_sel_i)
			STATUS_WHOLE: status_rdata_o = is_super ? psw_reg : 16'h0000;
			STATUS_FLAGS: status_rdata_o = {8'h00, psw_reg[7:0]};
			default:      status_rdata_o = 16'h0000;
		endcase
	end

	assign supervisor_o = is_super;
	assign trace_req_o  = insn_done_i & psw_reg[`PSW_TRACE_BIT];
	// Level seven edge bypasses the mask entirely
	assign irq_accept_o = irq_edge7_i ||
		(irq_level_i > psw_reg[`PSW_MASK_HI:`PSW_MASK_LO]);

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------
	always_comb begin
		exc_base_next = exc_base_reg;
		cache_next    = cache_reg;
		region0_next  = region0_reg;
		region1_next  = region1_reg;
		ram_base_next = ram_base_reg;
		periph_next   = periph_reg;
		ctl_fault_o   = 1'b0;
		if (ctl_wr_i) begin
			if (!is_super) begin
				ctl_fault_o = 1'b1;
			end else begin
				unique case (ctl_sel_i)
					`SEL_CACHE_CONTROL:
						cache_next = ctl_wdata_i & CACHE_IMPL_MASK;
					`SEL_REGION_ATTR_0:
						region0_next = ctl_wdata_i & REGION_IMPL_MASK;
					`SEL_REGION_ATTR_1:
						region1_next = ctl_wdata_i & REGION_IMPL_MASK;
					`SEL_EXC_TABLE_BASE:
						exc_base_next = {ctl_wdata_i[31:`EXC_BASE_LOW_BITS],
							20'h00000};
					`SEL_ONCHIP_RAM_BASE:
						ram_base_next = ctl_wdata_i & RAM_IMPL_MASK;
					`SEL_PERIPH_WIN_BASE:
						periph_next = ctl_wdata_i & PERIPH_IMPL_MASK;
					default: ctl_fault_o = 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			exc_base_reg <= 32'h0000_0000;
			cache_reg    <= 32'h0000_0000;
			region0_reg  <= 32'h0000_0000;
			region1_reg  <= 32'h0000_0000;
			ram_base_reg <= 32'h0000_0000;
			periph_reg   <= 32'h0000_0000;
		end else begin
			exc_base_reg <= exc_base_next;
			cache_reg    <= cache_next;
			region0_reg  <= region0_next;
			region1_reg  <= region1_next;
			ram_base_reg <= ram_base_next;
			periph_reg   <= periph_next;
		end
	end

	// Unknown selects read zero rather than stale data
	always_comb begin
		unique case (ctl_sel_i)
			`SEL_CACHE_CONTROL:   ctl_rdata_o = cache_reg;
			`SEL_REGION_ATTR_0:   ctl_rdata_o = region0_reg;
			`SEL_REGION_ATTR_1:   ctl_rdata_o = region1_reg;
			`SEL_EXC_TABLE_BASE:  ctl_rdata_o = exc_base_reg;
			`SEL_ONCHIP_RAM_BASE: ctl_rdata_o = ram_base_reg;
			`SEL_PERIPH_WIN_BASE: ctl_rdata_o = periph_reg;
			default:              ctl_rdata_o = 32'h0000_0000;
		endcase
	end

	assign cache_control_o = cache_reg;
	assign region_attr_0_o = region0_reg;
	assign region_attr_1_o = region1_reg;
	// RAM base low bits are not address; alignment is software's duty
	assign ram_base_o      = ram_base_reg;
	assign periph_base_o   = periph_reg;
	assign vector_addr_o   = exc_base_reg + {22'h000000, vector_disp_i};

	// ------------------------------------------------------------------
	// General registers: 0-7 data, 8-15 address
	// ------------------------------------------------------------------
	assign addr_byte = gpr_wr_i & gpr_wsel_i[3] & (gpr_size_i == SIZE_BYTE);
	assign gpr_size_fault_o = addr_byte;

	operand_merge u_merge (
		.old_value_i  (gpr_reg[gpr_wsel_i]),
		.result_i     (gpr_wdata_i),
		.size_i       (gpr_size_i),
		.is_address_i (gpr_wsel_i[3]),
		.merged_o     (merged)
	);

	always_comb begin
		gpr_next = gpr_reg;
		// Illegal byte write to address register is dropped
		if (gpr_wr_i && !addr_byte) begin
			gpr_next[gpr_wsel_i] = merged;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < 16; i++) begin
				gpr_reg[i] <= 32'h0000_0000;
			end
		end else begin
			gpr_reg <= gpr_next;
		end
	end

	assign gpr_rdata_o = gpr_reg[gpr_rsel_i];

endmodule

/* core_status_control_defines.svh */
/*
 * Constants for the core status and control register set: control
 * register select codes, status word field positions, reset values.
 * Assumes inclusion by bare name from design files.
 */
`ifndef CORE_STATUS_CONTROL_DEFINES_SVH
`define CORE_STATUS_CONTROL_DEFINES_SVH

// ----------------------------------------------------------------------
// Control register select codes
// ----------------------------------------------------------------------
`define SEL_CACHE_CONTROL      12'h002
`define SEL_REGION_ATTR_0      12'h004
`define SEL_REGION_ATTR_1      12'h005
`define SEL_EXC_TABLE_BASE     12'h801
`define SEL_ONCHIP_RAM_BASE    12'hC04
`define SEL_PERIPH_WIN_BASE    12'hC0F

// ----------------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------------
`define PSW_TRACE_BIT          15
`define PSW_SUPER_BIT          13
`define PSW_MASTER_BIT         12
`define PSW_MASK_HI            10
`define PSW_MASK_LO            8
`define PSW_PREDICT_BIT        7
`define PSW_FLAG_HI            4
`define PSW_WRITE_MASK         16'hB79F
`define FLAG_WRITE_MASK        8'h9F
`define PSW_RESET_HIGH         8'h27
`define PSW_RESET_FLAGS        8'h00

// ----------------------------------------------------------------------
// Alignment and top interrupt level
// ----------------------------------------------------------------------
`define EXC_BASE_LOW_BITS      20
`define RAM_BASE_LOW_BITS      15
`define INT_LEVEL_TOP          3'h7

`endif

/* core_status_control_pkg.sv */
/*
 * Types shared by the core status and control register set.
 * Assumes no surroundings beyond the design files that import it.
 */
package core_status_control_pkg;

	typedef enum logic [1:0] {
		SIZE_BYTE = 2'b00,
		SIZE_WORD = 2'b01,
		SIZE_LONG = 2'b10
	} op_size_t;

	typedef enum logic [1:0] {
		STATUS_NONE  = 2'b00,
		STATUS_WHOLE = 2'b01,
		STATUS_FLAGS = 2'b10
	} status_target_t;

endpackage

/* operand_merge.sv */
/*
 * Merges a result into a general register by operand size.
 * Assumes the caller never asks for a byte write to an address register.
 */
`timescale 1ns/1ns

module operand_merge
	import core_status_control_pkg::*;
(
	input  wire logic [31:0] old_value_i,
	input  wire logic [31:0] result_i,
	input  wire op_size_t    size_i,
	input  wire logic        is_address_i,
	output logic      [31:0] merged_o
);

	always_comb begin
		if (is_address_i) begin
			// Word results are sign extended; whole register is replaced
			if (size_i == SIZE_WORD) begin
				merged_o = {{16{result_i[15]}}, result_i[15:0]};
			end else begin
				merged_o = result_i;
			end
		end else begin
			unique case (size_i)
				SIZE_BYTE: merged_o = {old_value_i[31:8], result_i[7:0]};
				SIZE_WORD: merged_o = {old_value_i[31:16], result_i[15:0]};
				default:   merged_o = result_i;
			endcase
		end
	end

endmodule

/* core_status_control_chk.sv */
/*
 * Port checker for the core status and control register set.
 * Assumes it is bound to the block and sees only the block's ports.
 */
`timescale 1ns/1ns

module core_status_control_chk
	import core_status_control_pkg::*;
(
	input wire logic           mclk_i,
	input wire logic           reset_n_i,
	input wire status_target_t status_sel_i,
	input wire logic           status_wr_i,
	input wire logic [15:0]    status_wdata_i,
	input wire logic [15:0]    status_rdata_o,
	input wire logic           status_priv_fault_o,
	input wire logic           flags_wr_i,
	input wire logic           irq_taken_i,
	input wire logic [2:0]     irq_level_i,
	input wire logic           irq_edge7_i,
	input wire logic           irq_accept_o,
	input wire logic           insn_done_i,
	input wire logic           trace_req_o,
	input wire logic           supervisor_o,
	input wire logic [9:0]     vector_disp_i,
	input wire logic [31:0]    vector_addr_o,
	input wire logic           ctl_wr_i,
	input wire logic           ctl_fault_o,
	input wire logic [31:0]    cache_control_o,
	input wire logic [31:0]    ram_base_o,
	input wire logic [31:0]    periph_base_o,
	input wire logic           gpr_wr_i,
	input wire logic [3:0]     gpr_wsel_i,
	input wire op_size_t       gpr_size_i,
	input wire logic           gpr_size_fault_o
);

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	// ------------------------------------------------------------------
	// Sequences
	// ------------------------------------------------------------------
	sequence whole_wr_s;
		status_wr_i && status_sel_i == STATUS_WHOLE && supervisor_o &&
			!irq_taken_i && !flags_wr_i;
	endsequence

	sequence user_ctl_s;
		ctl_wr_i && !supervisor_o;
	endsequence

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	AST_WHOLE_WR: assert property (whole_wr_s ##1
		(status_sel_i == STATUS_WHOLE && supervisor_o) |->
		status_rdata_o == ($past(status_wdata_i) & 16'hB79F))
		else $error("status word write not read back masked");
	AST_USER_READ: assert property (status_sel_i == STATUS_WHOLE &&
		!supervisor_o |-> status_rdata_o == 16'h0000 && status_priv_fault_o)
		else $error("user view of whole status word not refused");
	AST_FLAG_VIEW: assert property (status_sel_i == STATUS_FLAGS |->
		status_rdata_o[15:8] == 8'h00 && status_rdata_o[6:5] == 2'b00)
		else $error("flag byte view shows upper or reserved bits");
	AST_TRACE_SRC: assert property (trace_req_o |-> insn_done_i)
		else $error("trace request without completed instruction");
	AST_TRACE_CLR: assert property (irq_taken_i |=> !trace_req_o)
		else $error("trace request right after interrupt entry");
	AST_IRQ_SUPER: assert property (irq_taken_i |=> supervisor_o)
		else $error("interrupt entry left user mode");
	AST_MASK: assert property (irq_taken_i ##1 1'b1 |-> irq_accept_o ==
		(irq_edge7_i || irq_level_i > $past(irq_level_i)))
		else $error("interrupt acceptance ignores new mask");
	AST_EDGE7: assert property (irq_edge7_i |-> irq_accept_o)
		else $error("edge level seven request was masked");
	AST_VEC_LOW: assert property (vector_addr_o[19:0] ==
		{10'h000, vector_disp_i})
		else $error("vector address low bits not the displacement");
	AST_USER_CTL: assert property (user_ctl_s |-> ctl_fault_o ##1
		($stable(cache_control_o) && $stable(ram_base_o) &&
		$stable(periph_base_o)))
		else $error("user control register write not refused");
	AST_BYTE_ADDR: assert property (gpr_size_fault_o == (gpr_wr_i &&
		gpr_wsel_i[3] && gpr_size_i == SIZE_BYTE))
		else $error("byte write to address register not flagged");

endmodule

bind core_status_control core_status_control_chk i_core_status_control_chk (
	.mclk_i, .reset_n_i, .status_sel_i, .status_wr_i, .status_wdata_i,
	.status_rdata_o, .status_priv_fault_o, .flags_wr_i, .irq_taken_i,
	.irq_level_i, .irq_edge7_i, .irq_accept_o, .insn_done_i, .trace_req_o,
	.supervisor_o, .vector_disp_i, .vector_addr_o, .ctl_wr_i, .ctl_fault_o,
	.cache_control_o, .ram_base_o, .periph_base_o, .gpr_wr_i, .gpr_wsel_i,
	.gpr_size_i, .gpr_size_fault_o
);

/* core_status_control_tb.sv */
/*
 * Self-checking bench for the core status and control register set.
 * Assumes the block alone, driven directly at its ports.
 */
`timescale 1ns/1ns

module core_status_control_tb import core_status_control_pkg::*;;

	typedef struct packed {
		logic [3:0]  sel;
		op_size_t    size;
		logic [31:0] data;
		logic [31:0] exp;
	} gpr_row_t;

	// Rows run in order; a row on the same register as the last builds on the value it left, except address-register word rows, which replace it whole
	localparam gpr_row_t ROWS [0:7] = '{
		'{4'h1, SIZE_LONG, 32'h11223344, 32'h11223344},
		'{4'h1, SIZE_WORD, 32'hFFFFBEEF, 32'h1122BEEF},
		'{4'h1, SIZE_BYTE, 32'hFFFFFFC5, 32'h1122BEC5},
		'{4'h3, SIZE_BYTE, 32'h00000080, 32'h00000080},
		'{4'hA, SIZE_LONG, 32'h55667788, 32'h55667788},
		'{4'hA, SIZE_WORD, 32'h00008001, 32'hFFFF8001},
		'{4'hA, SIZE_WORD, 32'hFFFF1234, 32'h00001234},
		'{4'hA, SIZE_BYTE, 32'h000000AA, 32'h00001234}};
	localparam logic [11:0] CODES [0:5] = '{12'h002, 12'h004, 12'h005,
		12'h801, 12'hC04, 12'hC0F};

	logic mclk_i = 1'b0, reset_n_i = 1'b0, flt;
	status_target_t status_sel_i = STATUS_NONE;
	logic status_wr_i = 1'b0, flags_wr_i = 1'b0, irq_taken_i = 1'b0;
	logic irq_edge7_i = 1'b0, insn_done_i = 1'b0, ctl_wr_i = 1'b0;
	logic gpr_wr_i = 1'b0;
	logic [15:0] status_wdata_i = 16'h0000;
	logic [4:0] flags_i = 5'h00;
	logic [2:0] irq_level_i = 3'h0;
	logic [9:0] vector_disp_i = 10'h000;
	logic [11:0] ctl_sel_i = 12'h000;
	logic [31:0] ctl_wdata_i = 32'h0, gpr_wdata_i = 32'h0;
	logic [3:0] gpr_wsel_i = 4'h0, gpr_rsel_i = 4'h0;
	op_size_t gpr_size_i = SIZE_LONG;
	logic [15:0] status_rdata_o;
	logic status_priv_fault_o, irq_accept_o, trace_req_o, supervisor_o;
	logic ctl_fault_o, gpr_size_fault_o;
	logic [31:0] vector_addr_o, ctl_rdata_o, cache_control_o, ram_base_o;
	logic [31:0] region_attr_0_o, region_attr_1_o, periph_base_o;
	logic [31:0] gpr_rdata_o;
	int error_cnt = 0, checks = 0, cyc = 0;

	core_status_control i_core_status_control (.mclk_i, .reset_n_i,
		.status_sel_i, .status_wr_i, .status_wdata_i, .status_rdata_o,
		.status_priv_fault_o, .flags_wr_i, .flags_i, .irq_taken_i,
		.irq_level_i, .irq_edge7_i, .irq_accept_o, .insn_done_i,
		.trace_req_o, .supervisor_o, .vector_disp_i, .vector_addr_o,
		.ctl_wr_i, .ctl_sel_i, .ctl_wdata_i, .ctl_rdata_o, .ctl_fault_o,
		.cache_control_o, .region_attr_0_o, .region_attr_1_o, .ram_base_o,
		.periph_base_o, .gpr_wr_i, .gpr_wsel_i, .gpr_size_i, .gpr_wdata_i,
		.gpr_rsel_i, .gpr_rdata_o, .gpr_size_fault_o);

	// ------------------------------------------------------------------
	// Clock, watchdog, shared tasks
	// ------------------------------------------------------------------
	always #4 mclk_i = ~mclk_i;

	// Whole run is under a hundred cycles; this catches a run that never reaches its report
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			final_report();
		end
	end

	task final_report();
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task psw_wr(input status_target_t s, input logic [15:0] d);
		@(posedge mclk_i);
		status_sel_i <= s;
		status_wr_i <= 1'b1;
		status_wdata_i <= d;
		#1 flt = status_priv_fault_o;
		@(posedge mclk_i);
		status_wr_i <= 1'b0;
		#1;
	endtask

	task psw_rd(input status_target_t s, input logic [15:0] e);
		@(posedge mclk_i);
		status_sel_i <= s;
		#1 chk(32'(status_rdata_o), 32'(e));
	endtask

	task ctl_wr(input logic [11:0] c, input logic [31:0] d);
		@(posedge mclk_i);
		ctl_wr_i <= 1'b1;
		ctl_sel_i <= c;
		ctl_wdata_i <= d;
		#1 flt = ctl_fault_o;
		@(posedge mclk_i);
		ctl_wr_i <= 1'b0;
		#1;
	endtask

	task irq(input logic [2:0] l);
		@(posedge mclk_i);
		irq_taken_i <= 1'b1;
		irq_level_i <= l;
		@(posedge mclk_i);
		irq_taken_i <= 1'b0;
		#1;
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (16) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk_i);
			gpr_wr_i <= 1'b1;
			gpr_wsel_i <= ROWS[i].sel;
			gpr_size_i <= ROWS[i].size;
			gpr_wdata_i <= ROWS[i].data;
			@(posedge mclk_i);
			gpr_wr_i <= 1'b0;
			gpr_rsel_i <= ROWS[i].sel;
			#1 chk(gpr_rdata_o, ROWS[i].exp);
		end
		// Row seven left a byte write to an address register selected
		@(posedge mclk_i);
		gpr_wr_i <= 1'b1;
		#1 chk(32'(gpr_size_fault_o), 32'h1);
		@(posedge mclk_i);
		gpr_wr_i <= 1'b0;
		#1 chk(gpr_rdata_o, 32'h00001234);
		psw_rd(STATUS_WHOLE, 16'h2700);
		chk(32'(supervisor_o), 32'h1);
		psw_wr(STATUS_WHOLE, 16'hFFFF);
		psw_rd(STATUS_WHOLE, 16'hB79F);
		@(posedge mclk_i);
		insn_done_i <= 1'b1;
		irq_level_i <= 3'h7;
		#1 chk(32'(trace_req_o), 32'h1);
		chk(32'(irq_accept_o), 32'h0);
		@(posedge mclk_i);
		insn_done_i <= 1'b0;
		irq_edge7_i <= 1'b1;
		#1 chk(32'(irq_accept_o), 32'h1);
		@(posedge mclk_i);
		irq_edge7_i <= 1'b0;
		flags_wr_i <= 1'b1;
		flags_i <= 5'h0A;
		@(posedge mclk_i);
		flags_wr_i <= 1'b0;
		psw_rd(STATUS_FLAGS, 16'h008A);
		psw_wr(STATUS_FLAGS, 16'h1234);
		psw_rd(STATUS_WHOLE, 16'hB714);
		irq(3'h3);
		psw_rd(STATUS_WHOLE, 16'h2314);
		for (int l = 0; l < 8; l++) begin
			@(posedge mclk_i);
			irq_level_i <= 3'(l);
			#1 chk(32'(irq_accept_o), 32'(l > 3));
		end
		// RAM base value kept on a 32 Kbyte boundary
		for (int i = 0; i < 6; i++) begin
			ctl_wr(CODES[i], {CODES[i], 20'h08000});
			chk(ctl_rdata_o, (CODES[i] == 12'h801) ? {CODES[i], 20'h0} :
				{CODES[i], 20'h08000});
		end
		chk(cache_control_o, 32'h00208000);
		chk(region_attr_0_o, 32'h00408000);
		chk(region_attr_1_o, 32'h00508000);
		chk(ram_base_o, 32'hC0408000);
		chk(periph_base_o, 32'hC0F08000);
		@(posedge mclk_i);
		vector_disp_i <= 10'h3FF;
		#1 chk(vector_addr_o, 32'h801003FF);
		ctl_wr(12'h003, 32'h00000001);
		chk(32'(flt), 32'h1);
		psw_wr(STATUS_WHOLE, 16'h0005);
		chk(32'(supervisor_o), 32'h0);
		psw_rd(STATUS_WHOLE, 16'h0000);
		psw_wr(STATUS_WHOLE, 16'h2700);
		chk(32'(flt), 32'h1);
		chk(32'(supervisor_o), 32'h0);
		psw_wr(STATUS_FLAGS, 16'hFF05);
		psw_rd(STATUS_FLAGS, 16'h0005);
		ctl_wr(12'h002, 32'h00000000);
		chk(32'(flt), 32'h1);
		chk(cache_control_o, 32'h00208000);
		irq(3'h7);
		chk(32'(supervisor_o), 32'h1);
		// Mid-run reset must restore the status word
		@(posedge mclk_i);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		psw_rd(STATUS_WHOLE, 16'h2700);
		final_report();
	end

endmodule
